// file: rtl/iq_path_defs.svh
// Register map, reset values and arithmetic constants of the I/Q modulation and gain path
// Notes on behaviour
// - Mode 000 bypasses; 001 and 010 mix I/Q into A/B with oscillator cos/sin.
// - Mode 011 and 100 give the negated-B sideband forms; other codes unspecified.
// - Oscillator frequency is 40-bit tuning word times sample rate over 2^40.
// - A 16-bit phase offset spans 0 to 360 degrees linearly.
// - Low-power select forces tuning word bits 31..0 to zero.
// - Half-power backoff lowers mixer gain by 3 dB to avoid saturation.
// - Phase trim is 13-bit signed; adjustment in radians is value over 16384.
// - Trim acts only when enabled; otherwise I and Q stay 90 degrees apart.
// - Optional 9-tap roll-off filter: 1, -4, 13, -51 mirrored, 610 centre.
// - Each channel has an enable and 12-bit gain scaling by gain over 4096.
// - Offset-binary: 0 min, 32768 mid, 65535 full; two's complement inverts MSB.
// - Without a mute condition the machine idles and gains are as programmed.
// - A mute event enters mute; soft ramps gains down, hard zeroes instantly.
// - At zero gain enter wait; leave after wait period and event released.
// - Unmute ramps gains back; new event re-mutes from current gain; then idle.
// - Auto-silence acts only when its enable bit is set.
`ifndef IQ_PATH_DEFS_SVH
`define IQ_PATH_DEFS_SVH

// Register byte offsets
`define ADDR_CTRL 8'h00
`define ADDR_TUNE_LO 8'h04
`define ADDR_TUNE_HI 8'h08
`define ADDR_PHASE 8'h0c
`define ADDR_TRIM 8'h10
`define ADDR_GAIN_A 8'h14
`define ADDR_GAIN_B 8'h18
`define ADDR_WAIT 8'h1c
`define ADDR_RATE 8'h20
`define ADDR_STATUS 8'h24
`define ADDR_MASK 8'h28
`define ADDR_STATE 8'h2c

// Reset values
`define CTRL_RESET 32'h0000_0000
`define GAIN_RESET 12'hfff
`define WAIT_RESET 16'h0010
`define RATE_RESET 13'h0010

// Arithmetic constants
`define LEVEL_FULL 13'h1000
`define GAIN_SHIFT 12
`define TRIM_SHIFT 14
`define MIX_SHIFT 15
`define BACKOFF_COEF 16'h5a82
`define ROLLOFF_SHIFT 9
`define LP_MASK_BITS 32

// Status bit positions
`define ST_MUTED 0
`define ST_RESTORED 1
`define ST_WAITING 2

`endif

// file: rtl/iq_path_pkg.sv
// Types and saturation helper shared by the I/Q modulation path
package iq_path_pkg;

  // Control register layout, highest field first, lowest field at bit 0
  typedef struct packed {
    logic [18:0] spare;
    logic sw_mute;
    logic soft_mute;
    logic twos_comp;
    logic auto_silence_enable;
    logic gain_b_en;
    logic gain_a_en;
    logic rolloff_compensation_select;
    logic quadrature_phase_trim_enable;
    logic half_power_backoff;
    logic oscillator_low_power_select;
    logic [2:0] single_sideband_mixer;
  } ctrl_t;

  typedef enum logic [1:0] {SIL_IDLE, SIL_MUTE, SIL_WAIT, SIL_UNMUTE} silence_t;

  typedef struct packed {
    logic signed [15:0] a;
    logic signed [15:0] b;
  } pair_t;

  // Clip a wide result to the signed 16-bit range
  function automatic logic signed [15:0] sat16(input logic signed [35:0] v);
    if (v > 36'sh0_0000_7fff) return 16'sh7fff;
    else if (v < 36'shf_ffff_8000) return 16'sh8000;
    else return v[15:0];
  endfunction : sat16

endpackage : iq_path_pkg

// file: rtl/quad_oscillator.sv
// Phase accumulator oscillator producing cosine and sine
`timescale 1ns/1ns
`include "iq_path_defs.svh"
module quad_oscillator #(
  parameter int TW = 40
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [TW-1:0] tune,
  input wire logic [15:0] offset,
  input wire logic low_power,
  output logic signed [15:0] cos_q,
  output logic signed [15:0] sin_q
);

  typedef struct packed {
    logic [TW-1:0] acc;
    logic signed [15:0] c;
    logic signed [15:0] s;
  } osc_t;

  osc_t s, next_s;

  // Quarter-wave sine table, 17 points on 0..90 degrees
  function automatic logic signed [15:0] quarter(input logic [4:0] k);
    case (k)
      5'h00: return 16'sh0000; 5'h01: return 16'sh0c8c; 5'h02: return 16'sh18f9;
      5'h03: return 16'sh2528; 5'h04: return 16'sh30fb; 5'h05: return 16'sh3c56;
      5'h06: return 16'sh471c; 5'h07: return 16'sh5133; 5'h08: return 16'sh5a82;
      5'h09: return 16'sh62f1; 5'h0a: return 16'sh6a6d; 5'h0b: return 16'sh70e2;
      5'h0c: return 16'sh7641; 5'h0d: return 16'sh7a7c; 5'h0e: return 16'sh7d89;
      5'h0f: return 16'sh7f61; default: return 16'sh7fff;
    endcase
  endfunction : quarter

  // Sine of a 6-bit phase by quadrant folding
  function automatic logic signed [15:0] sine(input logic [5:0] p);
    logic signed [15:0] m;
    m = p[4] ? quarter(5'h10 - {1'b0, p[3:0]}) : quarter({1'b0, p[3:0]});
    return p[5] ? -m : m;
  endfunction : sine

  // Accumulate and look up; offset is added at the top of the phase
  always_comb begin
    logic [TW-1:0] step;
    logic [15:0] ph;
    step = low_power ? {tune[TW-1:`LP_MASK_BITS], {`LP_MASK_BITS{1'b0}}} : tune;
    next_s = s;
    next_s.acc = s.acc + step;
    ph = s.acc[TW-1 -: 16] + offset;
    next_s.s = sine(ph[15:10]);
    next_s.c = sine(ph[15:10] + 6'h10);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign cos_q = s.c;
  assign sin_q = s.s;

endmodule : quad_oscillator

// file: rtl/channel_tail.sv
// Per-channel roll-off compensation, digital gain and output coding
`timescale 1ns/1ns
`include "iq_path_defs.svh"
module channel_tail #(
  parameter int TAPS = 9
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [15:0] x,
  input wire logic x_valid,
  input wire logic rolloff_sel,
  input wire logic [12:0] gain,
  input wire logic twos_comp,
  output logic [15:0] y,
  output logic y_valid
);

  localparam logic signed [11:0] COEF [TAPS] = '{12'sh001, -12'sh004, 12'sh00d, -12'sh033, 12'sh262,
    -12'sh033, 12'sh00d, -12'sh004, 12'sh001};

  typedef struct packed {
    logic [TAPS-1:0][15:0] tap;
    logic [15:0] y;
    logic v;
  } tail_t;

  tail_t s, next_s;

  // Shift taps on each sample, filter, scale, clip and recode
  // The window includes the arriving sample, so the centre tap lags by four samples
  always_comb begin
    logic [TAPS-1:0][15:0] w;
    logic signed [35:0] acc;
    logic signed [15:0] f;
    logic signed [15:0] g;
    w = {s.tap[TAPS-2:0], x};
    next_s = s;
    next_s.v = x_valid;
    acc = '0;
    for (int k = 0; k < TAPS; k++) begin
      acc = acc + 36'(signed'(w[k]) * COEF[k]);
    end
    f = rolloff_sel ? iq_path_pkg::sat16(acc >>> `ROLLOFF_SHIFT) : signed'(w[TAPS/2]);
    g = iq_path_pkg::sat16(36'(f * signed'({1'b0, gain})) >>> `GAIN_SHIFT);
    if (x_valid) begin
      next_s.tap = w;
      next_s.y = twos_comp ? g : {~g[15], g[14:0]};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign y = s.y;
  assign y_valid = s.v;

endmodule : channel_tail

// file: rtl/iq_modulation_path.sv
// Top of the I/Q modulation path: APB registers, mixer, trim and auto-silence
`timescale 1ns/1ns
`include "iq_path_defs.svh"
module iq_modulation_path (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Sample stream in
  input wire logic [15:0] I_DATA_IN,
  input wire logic [15:0] Q_DATA_IN,
  input wire logic DATA_VALID_IN,
  input wire logic MUTE_EVENT_IN,
  // Converter outputs
  output logic [15:0] A_DATA_OUT,
  output logic [15:0] B_DATA_OUT,
  output logic DATA_VALID_OUT,
  output logic IRQ_OUT
);

  typedef struct packed {
    iq_path_pkg::ctrl_t ctrl;
    logic [31:0] tune_lo;
    logic [7:0] tune_hi;
    logic [15:0] phase;
    logic [12:0] trim;
    logic [11:0] gain_a;
    logic [11:0] gain_b;
    logic [15:0] wait_len;
    logic [12:0] rate;
    logic [2:0] status;
    logic [2:0] mask;
    logic [31:0] rdata;
    iq_path_pkg::silence_t mstate;
    logic [12:0] level;
    logic [15:0] wcnt;
    logic signed [15:0] i1;
    logic signed [15:0] q1;
    logic v1;
    iq_path_pkg::pair_t mix;
    logic v2;
  } top_t;

  top_t s, next_s;
  logic signed [15:0] cos_q;
  logic signed [15:0] sin_q;
  logic [12:0] gain_eff [2];
  logic [15:0] y [2];
  logic y_valid [2];
  logic access;
  logic mapped;

  // Oscillator on the combined tuning word
  quad_oscillator #(.TW(40)) osc (
    .clk(REF_CLK_IN),
    .rst_n(RESETN_IN),
    .tune({s.tune_hi, s.tune_lo}),
    .offset(s.phase),
    .low_power(s.ctrl.oscillator_low_power_select),
    .cos_q(cos_q),
    .sin_q(sin_q)
  );

  // One filter and gain tail per output channel
  generate
    for (genvar ch = 0; ch < 2; ch++) begin : g_tail
      channel_tail #(.TAPS(9)) tail (
        .clk(REF_CLK_IN),
        .rst_n(RESETN_IN),
        .x(ch == 0 ? s.mix.a : s.mix.b),
        .x_valid(s.v2),
        .rolloff_sel(s.ctrl.rolloff_compensation_select),
        .gain(gain_eff[ch]),
        .twos_comp(s.ctrl.twos_comp),
        .y(y[ch]),
        .y_valid(y_valid[ch])
      );
    end
  endgenerate

  // Effective gain: programmed or unity, scaled by the silence level
  always_comb begin
    logic [12:0] ga;
    logic [12:0] gb;
    logic [25:0] pa;
    logic [25:0] pb;
    ga = s.ctrl.gain_a_en ? {1'b0, s.gain_a} : `LEVEL_FULL;
    gb = s.ctrl.gain_b_en ? {1'b0, s.gain_b} : `LEVEL_FULL;
    pa = ga * s.level;
    pb = gb * s.level;
    gain_eff[0] = pa[`GAIN_SHIFT +: 13];
    gain_eff[1] = pb[`GAIN_SHIFT +: 13];
  end

  // APB decode: no wait states, unmapped addresses answer with an error
  assign access = PSEL_IN && PENABLE_IN;
  always_comb begin
    case (PADDR_IN)
      `ADDR_CTRL, `ADDR_TUNE_LO, `ADDR_TUNE_HI, `ADDR_PHASE, `ADDR_TRIM, `ADDR_GAIN_A,
      `ADDR_GAIN_B, `ADDR_WAIT, `ADDR_RATE, `ADDR_STATUS, `ADDR_MASK, `ADDR_STATE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Next-state logic for registers, silence machine and mixer stage
  always_comb begin
    logic wr;
    logic ev;
    logic [2:0] hit;
    logic [2:0] w1c;
    logic [12:0] step;
    logic signed [15:0] ci;
    logic signed [15:0] si;
    logic signed [15:0] cq;
    logic signed [15:0] sq;
    logic signed [35:0] ra;
    logic signed [35:0] rb;
    logic signed [15:0] ma;
    logic signed [15:0] mb;
    ra = '0;
    rb = '0;
    next_s = s;
    wr = access && PWRITE_IN;
    hit = '0;
    w1c = '0;
    // Read data captured in the setup cycle
    if (PSEL_IN && !PENABLE_IN) begin
      case (PADDR_IN)
        `ADDR_CTRL: next_s.rdata = s.ctrl;
        `ADDR_TUNE_LO: next_s.rdata = s.tune_lo;
        `ADDR_TUNE_HI: next_s.rdata = {24'h0, s.tune_hi};
        `ADDR_PHASE: next_s.rdata = {16'h0, s.phase};
        `ADDR_TRIM: next_s.rdata = {19'h0, s.trim};
        `ADDR_GAIN_A: next_s.rdata = {20'h0, s.gain_a};
        `ADDR_GAIN_B: next_s.rdata = {20'h0, s.gain_b};
        `ADDR_WAIT: next_s.rdata = {16'h0, s.wait_len};
        `ADDR_RATE: next_s.rdata = {19'h0, s.rate};
        `ADDR_STATUS: next_s.rdata = {29'h0, s.status};
        `ADDR_MASK: next_s.rdata = {29'h0, s.mask};
        `ADDR_STATE: next_s.rdata = {3'h0, s.level, 14'h0, s.mstate};
        default: next_s.rdata = 32'h0;
      endcase
    end
    // Register writes in the access cycle
    if (wr) begin
      case (PADDR_IN)
        `ADDR_CTRL: next_s.ctrl = PWDATA_IN;
        `ADDR_TUNE_LO: next_s.tune_lo = PWDATA_IN;
        `ADDR_TUNE_HI: next_s.tune_hi = PWDATA_IN[7:0];
        `ADDR_PHASE: next_s.phase = PWDATA_IN[15:0];
        `ADDR_TRIM: next_s.trim = PWDATA_IN[12:0];
        `ADDR_GAIN_A: next_s.gain_a = PWDATA_IN[11:0];
        `ADDR_GAIN_B: next_s.gain_b = PWDATA_IN[11:0];
        `ADDR_WAIT: next_s.wait_len = PWDATA_IN[15:0];
        `ADDR_RATE: next_s.rate = PWDATA_IN[12:0];
        `ADDR_STATUS: w1c = PWDATA_IN[2:0];
        `ADDR_MASK: next_s.mask = PWDATA_IN[2:0];
        default: ;
      endcase
    end
    // Auto-silence machine; a zero rate still moves one step per cycle
    ev = MUTE_EVENT_IN || s.ctrl.sw_mute;
    step = (s.rate == 13'h0) ? 13'h1 : s.rate;
    case (s.mstate)
      iq_path_pkg::SIL_IDLE: begin
        next_s.level = `LEVEL_FULL;
        if (ev) begin
          next_s.mstate = iq_path_pkg::SIL_MUTE;
          hit[`ST_MUTED] = 1'b1;
        end
      end
      iq_path_pkg::SIL_MUTE: begin
        if (s.ctrl.soft_mute && s.level > step) begin
          next_s.level = s.level - step;
        end else begin
          next_s.level = 13'h0;
          next_s.wcnt = 16'h0;
          next_s.mstate = iq_path_pkg::SIL_WAIT;
          hit[`ST_WAITING] = 1'b1;
        end
      end
      iq_path_pkg::SIL_WAIT: begin
        next_s.level = 13'h0;
        if (s.wcnt < s.wait_len) begin
          next_s.wcnt = s.wcnt + 16'h1;
        end else if (!ev) begin
          next_s.mstate = iq_path_pkg::SIL_UNMUTE;
        end
      end
      iq_path_pkg::SIL_UNMUTE: begin
        if (ev) begin
          next_s.mstate = iq_path_pkg::SIL_MUTE;
          hit[`ST_MUTED] = 1'b1;
        end else if (`LEVEL_FULL - s.level > step) begin
          next_s.level = s.level + step;
        end else begin
          next_s.level = `LEVEL_FULL;
          next_s.mstate = iq_path_pkg::SIL_IDLE;
          hit[`ST_RESTORED] = 1'b1;
        end
      end
      default: next_s.mstate = iq_path_pkg::SIL_IDLE;
    endcase
    if (!s.ctrl.auto_silence_enable) begin
      next_s.mstate = iq_path_pkg::SIL_IDLE;
      next_s.level = `LEVEL_FULL;
      hit = '0;
    end
    // Sticky status: a new event wins over a clear in the same cycle
    next_s.status = (s.status & ~w1c) | hit;
    // Input stage: recode to signed
    next_s.v1 = DATA_VALID_IN;
    if (DATA_VALID_IN) begin
      next_s.i1 = s.ctrl.twos_comp ? I_DATA_IN : {~I_DATA_IN[15], I_DATA_IN[14:0]};
      next_s.q1 = s.ctrl.twos_comp ? Q_DATA_IN : {~Q_DATA_IN[15], Q_DATA_IN[14:0]};
    end
    // Mixer products scaled back to 16 bits
    ci = iq_path_pkg::sat16(36'(s.i1 * cos_q) >>> `MIX_SHIFT);
    si = iq_path_pkg::sat16(36'(s.i1 * sin_q) >>> `MIX_SHIFT);
    cq = iq_path_pkg::sat16(36'(s.q1 * cos_q) >>> `MIX_SHIFT);
    sq = iq_path_pkg::sat16(36'(s.q1 * sin_q) >>> `MIX_SHIFT);
    case (s.ctrl.single_sideband_mixer)
      3'h1: begin
        ra = 36'(ci) - 36'(sq);
        rb = 36'(si) + 36'(cq);
      end
      3'h2: begin
        ra = 36'(ci) + 36'(sq);
        rb = 36'(si) - 36'(cq);
      end
      3'h3: begin
        ra = 36'(ci) - 36'(sq);
        rb = -36'(si) - 36'(cq);
      end
      3'h4: begin
        ra = 36'(ci) + 36'(sq);
        rb = -36'(si) + 36'(cq);
      end
      default: begin
        ra = 36'(s.i1);
        rb = 36'(s.q1);
      end
    endcase
    if (s.ctrl.half_power_backoff) begin
      ra = (ra * 36'sh0_0000_5a82) >>> `MIX_SHIFT;
      rb = (rb * 36'sh0_0000_5a82) >>> `MIX_SHIFT;
    end
    ma = iq_path_pkg::sat16(ra);
    mb = iq_path_pkg::sat16(rb);
    // Trim leans B toward A by a small angle of trim over 16384 radians
    if (s.ctrl.quadrature_phase_trim_enable) begin
      mb = iq_path_pkg::sat16(36'(mb) + (36'(ma * signed'(s.trim)) >>> `TRIM_SHIFT));
    end
    next_s.v2 = s.v1;
    if (s.v1) begin
      next_s.mix.a = ma;
      next_s.mix.b = mb;
    end
  end

  // State register
  always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      s <= '0;
      s.ctrl <= `CTRL_RESET;
      s.gain_a <= `GAIN_RESET;
      s.gain_b <= `GAIN_RESET;
      s.wait_len <= `WAIT_RESET;
      s.rate <= `RATE_RESET;
      s.level <= `LEVEL_FULL;
      s.mstate <= iq_path_pkg::SIL_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // Outputs
  assign PRDATA_OUT = s.rdata;
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = access && !mapped;
  assign A_DATA_OUT = y[0];
  assign B_DATA_OUT = y[1];
  assign DATA_VALID_OUT = y_valid[0];
  assign IRQ_OUT = |(s.status & s.mask);

endmodule : iq_modulation_path

// file: sim/iq_path_sva.sv
// Port-level assertions for the I/Q modulation path
`timescale 1ns/1ns
module iq_path_sva (
  // Clock and reset
  input wire logic REF_CLK_IN,
  input wire logic RESETN_IN,
  // APB
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  // Stream
  input wire logic DATA_VALID_IN,
  input wire logic [15:0] A_DATA_OUT,
  input wire logic [15:0] B_DATA_OUT,
  input wire logic DATA_VALID_OUT
);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  // Bus phases
  sequence s_setup;
    PSEL_IN && !PENABLE_IN;
  endsequence
  sequence s_access;
    PSEL_IN && PENABLE_IN;
  endsequence
  // Bus answers
  a_ready_high: assert property (s_setup ##1 s_access |-> PREADY_OUT) else $error("access not ready");
  a_err_unmapped: assert property (s_access ##0 (PADDR_IN > 8'h2c) |-> PSLVERR_OUT) else $error("no error");
  a_err_mapped: assert property (s_access ##0 (PADDR_IN <= 8'h2c && PADDR_IN[1:0] == 2'h0) |-> !PSLVERR_OUT)
    else $error("false error");
  a_err_idle: assert property (!(PSEL_IN && PENABLE_IN) |-> !PSLVERR_OUT) else $error("error outside access");
  a_rdata_hold: assert property ((!$past(PSEL_IN) || $past(PENABLE_IN)) |-> $stable(PRDATA_OUT))
    else $error("read data moved");
  // Stream timing
  a_valid_latency: assert property (DATA_VALID_IN |-> ##3 DATA_VALID_OUT) else $error("sample lost");
  a_valid_cause: assert property (DATA_VALID_OUT |-> $past(DATA_VALID_IN, 3)) else $error("spurious sample");
  a_out_hold: assert property (!DATA_VALID_OUT |-> $stable(A_DATA_OUT) && $stable(B_DATA_OUT))
    else $error("output moved");
endmodule : iq_path_sva

bind iq_modulation_path iq_path_sva chk (.REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .DATA_VALID_IN(DATA_VALID_IN), .A_DATA_OUT(A_DATA_OUT),
  .B_DATA_OUT(B_DATA_OUT), .DATA_VALID_OUT(DATA_VALID_OUT));

// file: sim/sample_source.sv
// Upstream lane receiver model feeding I/Q samples
`timescale 1ns/1ns
module sample_source (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Request from the bench
  input wire logic go_in,
  input wire logic [15:0] i_in,
  input wire logic [15:0] q_in,
  // Stream out
  output logic [15:0] i_out,
  output logic [15:0] q_out,
  output logic valid_out
);
  // Outside a sample the lines toggle so stale data is never mistaken for fresh
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) {i_out, q_out, valid_out} <= '0;
    else if (go_in) {i_out, q_out, valid_out} <= {i_in, q_in, 1'b1};
    else {i_out, q_out, valid_out} <= {~i_out, ~q_out, 1'b0};
  end
endmodule : sample_source

// file: sim/iq_modulation_path_test.sv
// Self-checking bench for the I/Q modulation path
`timescale 1ns/1ns
`include "iq_path_defs.svh"
module iq_modulation_path_test;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic go = 1'b0;
  logic mute_ev = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] i_src = 16'h0;
  logic [15:0] q_src = 16'h0;
  logic [31:0] prdata, rd;
  logic pready, perr, err, irq, vin, vout;
  logic [15:0] i_d, q_d, a_d, b_d, ra, rb;
  int n_fail = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_out = 0;

  // Clock
  initial forever #50 clk = ~clk;

  iq_modulation_path dut (.REF_CLK_IN(clk), .RESETN_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(perr), .I_DATA_IN(i_d), .Q_DATA_IN(q_d), .DATA_VALID_IN(vin), .MUTE_EVENT_IN(mute_ev),
    .A_DATA_OUT(a_d), .B_DATA_OUT(b_d), .DATA_VALID_OUT(vout), .IRQ_OUT(irq));
  sample_source src (.clk_in(clk), .rst_n_in(rst_n), .go_in(go), .i_in(i_src), .q_in(q_src),
    .i_out(i_d), .q_out(q_d), .valid_out(vin));

  // Output capture and hang guard, on the falling edge so registered outputs have settled
  always @(negedge clk) begin
    cyc++;
    if (vout === 1'b1) begin
      n_out++;
      ra = a_d;
      rb = b_d;
    end
    if (cyc == 6000) begin
      n_fail++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Compare with a few codes of rounding slack
  task automatic near(input logic [15:0] got, input logic [15:0] exp);
    logic signed [15:0] d;
    d = got - exp;
    chk({31'h0, $isunknown(got) || d > 16'sd4 || d < -16'sd4}, 32'h0);
  endtask : near

  // One APB transfer, held until ready is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = perr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask : rdchk

  task automatic flag(input logic exp);
    @(negedge clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask : flag

  // Send n identical samples plus four more, so the value reaches the centre tap, and wait for all
  task automatic run(input int n, input logic [15:0] i, input logic [15:0] q);
    int start;
    start = n_out;
    @(posedge clk);
    go <= 1'b1;
    i_src <= i;
    q_src <= q;
    repeat (n + 4) @(posedge clk);
    go <= 1'b0;
    repeat (12) @(negedge clk) if (n_out == start + n + 4) break;
    chk(32'(n_out - start), 32'(n + 4));
  endtask : run

  task automatic t_reset();
    rdchk(`ADDR_CTRL, `CTRL_RESET);
    rdchk(`ADDR_GAIN_A, 32'h0000_0fff);
    rdchk(`ADDR_GAIN_B, 32'h0000_0fff);
    rdchk(`ADDR_WAIT, 32'h0000_0010);
    rdchk(`ADDR_RATE, 32'h0000_0010);
    rdchk(`ADDR_STATE, 32'h1000_0000);
    rdchk(8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("register reset test done");
  endtask : t_reset

  task automatic t_path();
    run(1, 16'h1234, 16'habcd);
    chk({ra, rb}, 32'h1234_abcd);
    wr(`ADDR_CTRL, 32'h0000_0400);
    run(1, 16'h1234, 16'habcd);
    chk({ra, rb}, 32'h1234_abcd);
    wr(`ADDR_CTRL, 32'h0000_0180);
    wr(`ADDR_GAIN_A, 32'h0000_0800);
    wr(`ADDR_GAIN_B, 32'h0000_0400);
    run(1, 16'hc000, 16'h4000);
    chk({ra, rb}, 32'ha000_7000);
    wr(`ADDR_CTRL, 32'h0000_0440);
    run(12, 16'h1000, 16'h1000);
    chk({ra, rb}, 32'h1080_1080);
    run(12, 16'h7f00, 16'h8100);
    chk({ra, rb}, 32'h7fff_8000);
    $display("data path test done");
  endtask : t_path

  task automatic t_mix();
    logic [15:0] bs [4];
    bs = '{16'h1fff, 16'he001, 16'he001, 16'h1fff};
    wr(`ADDR_CTRL, 32'h0000_0408);
    wr(`ADDR_TUNE_LO, 32'hffff_ffff);
    for (int m = 1; m < 5; m++) begin
      wr(`ADDR_CTRL, 32'h0000_0408 | m);
      run(1, 16'h4000, 16'h2000);
      near(ra, 16'h3fff);
      near(rb, bs[m-1]);
    end
    wr(`ADDR_CTRL, 32'h0000_0419);
    run(1, 16'h4000, 16'h2000);
    near(ra, 16'h2d41);
    near(rb, 16'h16a0);
    wr(`ADDR_PHASE, 32'h0000_4000);
    wr(`ADDR_CTRL, 32'h0000_0409);
    run(1, 16'h4000, 16'h2000);
    near(ra, 16'he001);
    near(rb, 16'h3fff);
    wr(`ADDR_PHASE, 32'h0);
    $display("mixer test done");
  endtask : t_mix

  task automatic t_trim();
    wr(`ADDR_TRIM, 32'h0000_0800);
    wr(`ADDR_CTRL, 32'h0000_0400);
    run(1, 16'h4000, 16'h0000);
    chk({16'h0, rb}, 32'h0);
    wr(`ADDR_CTRL, 32'h0000_0420);
    run(1, 16'h4000, 16'h0000);
    near(rb, 16'h0800);
    wr(`ADDR_TRIM, 32'h0000_1000);
    run(1, 16'h4000, 16'h0000);
    near(rb, 16'hf000);
    $display("phase trim test done");
  endtask : t_trim

  task automatic t_silence();
    wr(`ADDR_CTRL, 32'h0000_0400);
    wr(`ADDR_MASK, 32'h0000_0007);
    mute_ev <= 1'b1;
    repeat (5) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h1000_0000);
    flag(1'b0);
    wr(`ADDR_CTRL, 32'h0000_0600);
    repeat (5) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h0000_0002);
    run(1, 16'h1000, 16'h1000);
    chk({ra, rb}, 32'h0);
    rdchk(`ADDR_STATUS, 32'h0000_0005);
    flag(1'b1);
    wr(`ADDR_MASK, 32'h0);
    flag(1'b0);
    mute_ev <= 1'b0;
    repeat (400) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h1000_0000);
    rdchk(`ADDR_STATUS, 32'h0000_0007);
    wr(`ADDR_MASK, 32'h0000_0007);
    flag(1'b1);
    wr(`ADDR_STATUS, 32'h0000_0007);
    flag(1'b0);
    run(1, 16'h1000, 16'h1000);
    chk({ra, rb}, 32'h1000_1000);
    wr(`ADDR_CTRL, 32'h0000_0e00);
    mute_ev <= 1'b1;
    repeat (5) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h0fb0_0001);
    chk({30'h0, rd[1:0]}, 32'h1);
    chk({31'h0, rd[28:16] == 13'h0}, 32'h0);
    mute_ev <= 1'b0;
    repeat (700) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h1000_0000);
    // Software mute as the event source, hard action
    wr(`ADDR_CTRL, 32'h0000_1600);
    repeat (5) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h0000_0002);
    wr(`ADDR_CTRL, 32'h0000_0600);
    repeat (300) @(posedge clk);
    rdchk(`ADDR_STATE, 32'h1000_0000);
    $display("auto silence test done");
  endtask : t_silence

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_path();
    t_mix();
    t_trim();
    t_silence();
    print_verdict();
  end
endmodule : iq_modulation_path_test
